/* hdl/rtc_port_pkg.sv */
// Purpose: constants and carriers for the clock host bus interface
// Assumes: one 200 MHz clock, host pins arrive asynchronously
// Notes:
// Notes on behaviour
// - a selected write stores the data bus at the write strobe's rising edge
// - while read strobe and a bank select are low, drive the selected byte
// - in the clock bank, A0 picks pointer register or data register
// - in the extended RAM, A5 high always reaches the page register
// - in the extended RAM, A5 low lets A0-A4 pick a byte of the page
// - standby low ignores every access and releases the data bus; contents kept
// - standby during a cycle drops it at once, like select loss; the write is not stored
// - four rate select bits of control A choose the square wave frequency
// - interrupt pin is active low open drain, following the summary flag bit 7
// - alarm, update done and periodic sources raise it when enabled in control B
// - reset pin low clears the three enables, four flags and square wave enable
// - reset pin low keeps the interrupt pin released
// - reset pin low refuses host access to the clock bank
// - pointer register selects one of 64 clock bank locations
// - page register selects one of 128 pages; aliased across A0-A4
package rtc_port_pkg;
  localparam logic [5:0] REG_A          = 6'h0A;
  localparam logic [5:0] REG_B          = 6'h0B;
  localparam logic [5:0] REG_C          = 6'h0C;
  localparam logic [5:0] REG_D          = 6'h0D;
  localparam int         A_UPDATE_BIT   = 7;
  localparam int         B_PIE_BIT      = 6;
  localparam int         B_AIE_BIT      = 5;
  localparam int         B_UIE_BIT      = 4;
  localparam int         B_SQUARE_WAVE_ENABLE_BIT     = 3;
  localparam logic [7:0] REG_D_VALUE    = 8'h80;
  localparam int         PAGE_SEL_BIT   = 5;
  localparam int         DIV_W          = 15;
  localparam logic [3:0] TAP_RS1        = 4'h6;
  localparam logic [3:0] TAP_RS2        = 4'h7;
  localparam logic [3:0] TAP_OFFSET     = 4'h2;
  localparam logic [7:0] AXI_IRQ_STATUS = 8'h00;
  localparam logic [7:0] AXI_IRQ_MASK   = 8'h04;
  localparam logic [7:0] AXI_HOST_STAT  = 8'h08;
  localparam int         EV_WRITE_BIT   = 0;
  localparam int         EV_READ_BIT    = 1;
  localparam int         EV_REFUSE_BIT  = 2;
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;

  typedef enum logic [2:0] {T_NONE, T_PTR, T_CLK, T_PAGE, T_EXTENDED_RAM_SELECT} target_e;

  typedef struct packed {
    logic       rtc_sel_n;
    logic       extended_ram_select_n;
    logic [5:0] addr;
    logic       rd_n;
    logic       wr_n;
    logic [7:0] data;
    logic       access_inhibit_n;
    logic       reset_pin_n;
  } host_in_s;

  typedef struct packed {
    logic [7:0] data;
    logic       data_oe;
    logic       irq_n;
    logic       irq_oe;
    logic       square_wave_out;
  } host_out_s;

  typedef struct packed {
    logic alarm;
    logic update_done;
    logic periodic;
    logic osc_tick;
  } rtc_event_s;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_s;

  typedef struct packed {
    host_in_s               sync1;
    host_in_s               sync2;
    host_in_s               prev;
    logic                   armed;
    logic [5:0]             ptr;
    logic [6:0]             page;
    logic [63:0][7:0]       clk_mem;
    logic [4095:0][7:0]     extended_ram_select;
    logic                   periodic_flag;
    logic                   alarm_flag;
    logic                   update_done_flag;
    logic                   summary_interrupt_flag;
    logic [DIV_W-1:0]       div;
    host_out_s              pins;
    logic [2:0]             irq_status;
    logic [2:0]             irq_mask;
    logic                   sys_irq;
    logic                   aw_got;
    logic [7:0]             aw_addr;
    logic                   w_got;
    logic [31:0]            w_data;
    logic [3:0]             w_strb;
    axi_rsp_s               axi;
  } state_s;
endpackage

/* hdl/rtc_host_bus_interface.sv */
// Purpose: host port of the clock: clock bank, paged extended RAM, interrupt pin
// Assumes: host pins held stable a few clocks around each strobe edge
// Notes: events and oscillator tick come from timekeeping logic on clk
//
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module rtc_host_bus_interface (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    reset,
  // host pins
  input  wire rtc_port_pkg::host_in_s  host_in,
  output var  rtc_port_pkg::host_out_s host_out,
  // timekeeping events
  input  wire rtc_port_pkg::rtc_event_s events,
  // software access
  input  wire rtc_port_pkg::axi_req_s  axi_req,
  output var  rtc_port_pkg::axi_rsp_s  axi_rsp,
  output logic                         sys_irq
);
  import rtc_port_pkg::*;

  state_s st_ff;
  state_s nxt_st;

  function automatic target_e target_f(input logic rtc_ok, input logic xr_ok, input logic [5:0] a);
    target_e t;
    t = T_NONE;
    if (rtc_ok) begin
      t = a[0] ? T_CLK : T_PTR;
    end else if (xr_ok) begin
      t = a[PAGE_SEL_BIT] ? T_PAGE : T_EXTENDED_RAM_SELECT;
    end
    return t;
  endfunction

  // maps rate select to the divider bit whose toggle rate is the square wave
  function automatic logic [3:0] tap_f(input logic [3:0] rs);
    logic [3:0] t;
    t = rs - TAP_OFFSET;
    if (rs == 4'h1) begin
      t = TAP_RS1;
    end else if (rs == 4'h2) begin
      t = TAP_RS2;
    end
    return t;
  endfunction

  host_in_s   h;
  logic       rst_pin;
  logic       rtc_ok;
  logic       xr_ok;
  logic       wr_rise;
  logic       rd_rise;
  logic       strobe_fall;
  logic       commit;
  logic       refused;
  target_e    tgt;
  logic [7:0] rd_byte;
  logic [7:0] reg_b;
  logic [2:0] ev;
  logic       clr_flags;
  logic [3:0] rs;
  logic       periodic_irq_enable;
  logic       alarm_irq_enable;
  logic       update_done_irq_enable;

  always_comb begin
    nxt_st = st_ff;
    h      = st_ff.sync2;
    // first stage is read only by the second
    nxt_st.sync1 = host_in;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.prev  = st_ff.sync2;

    rst_pin = !h.reset_pin_n;
    xr_ok   = !h.extended_ram_select_n && h.access_inhibit_n;
    rtc_ok  = !h.rtc_sel_n && h.access_inhibit_n && !rst_pin;
    tgt     = target_f(rtc_ok, xr_ok, h.addr);

    wr_rise     = h.wr_n && !st_ff.prev.wr_n;
    rd_rise     = h.rd_n && !st_ff.prev.rd_n;
    strobe_fall = (!h.rd_n && st_ff.prev.rd_n) || (!h.wr_n && st_ff.prev.wr_n);
    refused     = strobe_fall && ((!h.rtc_sel_n && rst_pin)
                  || ((!h.rtc_sel_n || !h.extended_ram_select_n) && !h.access_inhibit_n));

    // losing the select or standby mid cycle drops the cycle
    nxt_st.armed = (tgt != T_NONE) && !h.wr_n;
    commit       = wr_rise && st_ff.armed && (tgt != T_NONE);

    if (commit) begin
      unique case (tgt)
        T_PTR:  nxt_st.ptr = h.data[5:0];
        T_PAGE: nxt_st.page = h.data[6:0];
        T_EXTENDED_RAM_SELECT: nxt_st.extended_ram_select[{st_ff.page, h.addr[4:0]}] = h.data;
        T_CLK: begin
          if (st_ff.ptr == REG_A) begin
            nxt_st.clk_mem[REG_A] = {1'b0, h.data[6:0]};
          end else if (st_ff.ptr != REG_C && st_ff.ptr != REG_D) begin
            nxt_st.clk_mem[st_ff.ptr] = h.data;
          end
        end
        T_NONE: ;
      endcase
    end

    unique case (st_ff.ptr)
      REG_C:   rd_byte = {st_ff.summary_interrupt_flag, st_ff.periodic_flag,
                          st_ff.alarm_flag, st_ff.update_done_flag, 4'h0};
      REG_D:   rd_byte = REG_D_VALUE;
      default: rd_byte = st_ff.clk_mem[st_ff.ptr];
    endcase
    nxt_st.pins.data_oe = (tgt != T_NONE) && !h.rd_n;
    unique case (tgt)
      T_PTR:  nxt_st.pins.data = {2'h0, st_ff.ptr};
      T_CLK:  nxt_st.pins.data = rd_byte;
      T_PAGE: nxt_st.pins.data = {1'b0, st_ff.page};
      T_EXTENDED_RAM_SELECT: nxt_st.pins.data = st_ff.extended_ram_select[{st_ff.page, h.addr[4:0]}];
      T_NONE: nxt_st.pins.data = 8'h00;
    endcase

    // reading control C clears the flags after the byte has been shown
    clr_flags = rd_rise && (tgt == T_CLK) && (st_ff.ptr == REG_C);
    nxt_st.periodic_flag    = (st_ff.periodic_flag && !clr_flags) || events.periodic;
    nxt_st.alarm_flag       = (st_ff.alarm_flag && !clr_flags) || events.alarm;
    nxt_st.update_done_flag = (st_ff.update_done_flag && !clr_flags) || events.update_done;
    if (rst_pin) begin
      nxt_st.clk_mem[REG_B][B_PIE_BIT]  = 1'b0;
      nxt_st.clk_mem[REG_B][B_AIE_BIT]  = 1'b0;
      nxt_st.clk_mem[REG_B][B_UIE_BIT]  = 1'b0;
      nxt_st.clk_mem[REG_B][B_SQUARE_WAVE_ENABLE_BIT] = 1'b0;
      nxt_st.periodic_flag    = 1'b0;
      nxt_st.alarm_flag       = 1'b0;
      nxt_st.update_done_flag = 1'b0;
    end
    reg_b = nxt_st.clk_mem[REG_B];
    periodic_irq_enable   = reg_b[B_PIE_BIT];
    alarm_irq_enable   = reg_b[B_AIE_BIT];
    update_done_irq_enable   = reg_b[B_UIE_BIT];
    nxt_st.summary_interrupt_flag = (nxt_st.periodic_flag && periodic_irq_enable)
                                  || (nxt_st.alarm_flag && alarm_irq_enable)
                                  || (nxt_st.update_done_flag && update_done_irq_enable);
    nxt_st.pins.irq_n  = 1'b0;
    nxt_st.pins.irq_oe = nxt_st.summary_interrupt_flag && !rst_pin;

    rs = st_ff.clk_mem[REG_A][3:0];
    if (events.osc_tick) begin
      nxt_st.div = st_ff.div + 1'b1;
    end
    // enable taken from the registered byte so a write takes effect one clock later
    nxt_st.pins.square_wave_out = st_ff.clk_mem[REG_B][B_SQUARE_WAVE_ENABLE_BIT] && (rs != 4'h0)
                                  && st_ff.div[tap_f(rs)];

    // block events for software
    ev = 3'h0;
    ev[EV_WRITE_BIT]  = commit;
    ev[EV_READ_BIT]   = rd_rise && (tgt != T_NONE);
    ev[EV_REFUSE_BIT] = refused;

    // software side: write address and data taken in either order
    if (axi_req.awvalid && st_ff.axi.awready) begin
      nxt_st.aw_got  = 1'b1;
      nxt_st.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && st_ff.axi.wready) begin
      nxt_st.w_got  = 1'b1;
      nxt_st.w_data = axi_req.wdata;
      nxt_st.w_strb = axi_req.wstrb;
    end
    if (st_ff.axi.bvalid && axi_req.bready) begin
      nxt_st.axi.bvalid = 1'b0;
    end
    if (st_ff.aw_got && st_ff.w_got && !st_ff.axi.bvalid) begin
      nxt_st.aw_got     = 1'b0;
      nxt_st.w_got      = 1'b0;
      nxt_st.axi.bvalid = 1'b1;
      nxt_st.axi.bresp  = RESP_OKAY;
      unique case (st_ff.aw_addr)
        AXI_IRQ_STATUS: begin
          if (st_ff.w_strb[0]) begin
            nxt_st.irq_status = st_ff.irq_status & ~st_ff.w_data[2:0];
          end
        end
        AXI_IRQ_MASK: begin
          if (st_ff.w_strb[0]) begin
            nxt_st.irq_mask = st_ff.w_data[2:0];
          end
        end
        AXI_HOST_STAT: ;
        default: nxt_st.axi.bresp = RESP_SLVERR;
      endcase
    end
    // set wins over a clear in the same cycle
    nxt_st.irq_status = nxt_st.irq_status | ev;
    nxt_st.sys_irq    = |(nxt_st.irq_status & nxt_st.irq_mask);
    nxt_st.axi.awready = !nxt_st.aw_got && !nxt_st.axi.bvalid;
    nxt_st.axi.wready  = !nxt_st.w_got && !nxt_st.axi.bvalid;

    if (st_ff.axi.rvalid && axi_req.rready) begin
      nxt_st.axi.rvalid = 1'b0;
    end
    if (axi_req.arvalid && st_ff.axi.arready) begin
      nxt_st.axi.rvalid = 1'b1;
      nxt_st.axi.rresp  = RESP_OKAY;
      unique case (axi_req.araddr)
        AXI_IRQ_STATUS: nxt_st.axi.rdata = {29'h0, st_ff.irq_status};
        AXI_IRQ_MASK:   nxt_st.axi.rdata = {29'h0, st_ff.irq_mask};
        AXI_HOST_STAT:  nxt_st.axi.rdata = {15'h0, st_ff.page, 2'h0, st_ff.ptr,
                                            st_ff.summary_interrupt_flag, rst_pin};
        default: begin
          nxt_st.axi.rdata = 32'h0000_0000;
          nxt_st.axi.rresp = RESP_SLVERR;
        end
      endcase
    end
    nxt_st.axi.arready = !nxt_st.axi.rvalid;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      // sampled pins start at their idle high level, so no false strobe edge follows reset
      st_ff <= '{sync1: '1, sync2: '1, prev: '1, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign host_out = st_ff.pins;
  assign axi_rsp  = st_ff.axi;
  assign sys_irq  = st_ff.sys_irq;

  // checks
  logic    chk_rst;
  target_e chk_tgt;
  assign chk_rst = !st_ff.sync2.reset_pin_n;
  assign chk_tgt = target_f(!st_ff.sync2.rtc_sel_n && st_ff.sync2.access_inhibit_n && !chk_rst,
                            !st_ff.sync2.extended_ram_select_n && st_ff.sync2.access_inhibit_n,
                            st_ff.sync2.addr);

  sequence wr_low_s;
    st_ff.armed;
  endsequence
  sequence wr_rise_s;
    st_ff.sync2.wr_n && !st_ff.prev.wr_n && chk_tgt == T_EXTENDED_RAM_SELECT;
  endsequence

  extended_ram_select_store_a: assert property (@(posedge clk) disable iff (reset)
    wr_low_s ##0 wr_rise_s |=> st_ff.extended_ram_select[$past({st_ff.page, st_ff.sync2.addr[4:0]})]
      == $past(st_ff.sync2.data))
    else $error("extended RAM byte not stored on write strobe rise");
  read_drive_a: assert property (@(posedge clk) disable iff (reset)
    (chk_tgt != T_NONE && !st_ff.sync2.rd_n) |=> st_ff.pins.data_oe)
    else $error("selected read did not drive the data bus");
  ptr_store_a: assert property (@(posedge clk) disable iff (reset)
    (st_ff.armed && st_ff.sync2.wr_n && !st_ff.prev.wr_n && chk_tgt == T_PTR)
      |=> st_ff.ptr == $past(st_ff.sync2.data[5:0]))
    else $error("pointer register not written with A0 low");
  page_store_a: assert property (@(posedge clk) disable iff (reset)
    (st_ff.armed && st_ff.sync2.wr_n && !st_ff.prev.wr_n && chk_tgt == T_PAGE)
      |=> st_ff.page == $past(st_ff.sync2.data[6:0]))
    else $error("page register not written with A5 high");
  standby_quiet_a: assert property (@(posedge clk) disable iff (reset)
    !st_ff.sync2.access_inhibit_n |=> !st_ff.pins.data_oe && !st_ff.armed)
    else $error("access not inhibited in standby");
  sqw_off_a: assert property (@(posedge clk) disable iff (reset)
    (st_ff.clk_mem[REG_A][3:0] == 4'h0 || !st_ff.clk_mem[REG_B][B_SQUARE_WAVE_ENABLE_BIT])
      |=> !st_ff.pins.square_wave_out)
    else $error("square wave running while disabled");
  irq_follow_a: assert property (@(posedge clk) disable iff (reset)
    !chk_rst |-> st_ff.pins.irq_oe == st_ff.summary_interrupt_flag || $changed(chk_rst))
    else $error("interrupt pin does not follow the summary flag");
  irq_source_a: assert property (@(posedge clk) disable iff (reset)
    (events.alarm && st_ff.clk_mem[REG_B][B_AIE_BIT] && !chk_rst)
      |=> st_ff.summary_interrupt_flag)
    else $error("enabled alarm did not raise the summary flag");
  reset_clear_a: assert property (@(posedge clk) disable iff (reset)
    chk_rst |=> st_ff.clk_mem[REG_B][6:3] == 4'h0 && !st_ff.periodic_flag
      && !st_ff.alarm_flag && !st_ff.update_done_flag && !st_ff.summary_interrupt_flag)
    else $error("reset pin did not clear enables and flags");
  irq_release_a: assert property (@(posedge clk) disable iff (reset)
    chk_rst |=> !st_ff.pins.irq_oe)
    else $error("interrupt pin driven during reset pin");
  rtc_refuse_a: assert property (@(posedge clk) disable iff (reset)
    chk_rst |-> chk_tgt != T_PTR && chk_tgt != T_CLK)
    else $error("clock bank reachable during reset pin");
endmodule
`default_nettype wire

/* bench/host_model.sv */
// Purpose: host processor model driving the parallel pins
// Assumes: every strobe phase lasts at least 4 clk
// Notes: a released data wire shows the inverse of its last value
`timescale 1ns/10ps
`default_nettype none
module host_model (
  // clock
  input  wire logic                    clk,
  // level pins set by the bench
  input  wire logic                    access_inhibit_n,
  input  wire logic                    reset_pin_n,
  // device pins
  input  wire rtc_port_pkg::host_out_s host_out,
  output var  rtc_port_pkg::host_in_s  host_in
);
  import rtc_port_pkg::*;
  logic       rtc_n = 1'b1;
  logic       ram_n = 1'b1;
  logic       rd_n  = 1'b1;
  logic       wr_n  = 1'b1;
  logic       drv   = 1'b0;
  logic [5:0] adr   = 6'h00;
  logic [7:0] wdat  = 8'h00;
  logic [7:0] last  = 8'h00;
  always_comb begin
    host_in = '{rtc_n, ram_n, adr, rd_n, wr_n, 8'h00, access_inhibit_n, reset_pin_n};
    host_in.data = drv ? wdat : (host_out.data_oe ? host_out.data : ~last);
  end
  always @(posedge clk) last <= host_in.data;
  // one select at a time, never both strobes
  task automatic hw(input logic ram, input logic [5:0] a, input logic [7:0] d);
    rtc_n <= ram;
    ram_n <= ~ram;
    adr <= a;
    wdat <= d;
    drv <= 1'b1;
    repeat (4) @(posedge clk);
    wr_n <= 1'b0;
    repeat (4) @(posedge clk);
    wr_n <= 1'b1;  // select and data held past the rising edge
    repeat (4) @(posedge clk);
    rtc_n <= 1'b1;
    ram_n <= 1'b1;
    drv <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic hr(input logic ram, input logic [5:0] a, output logic [7:0] d, output logic oe);
    rtc_n <= ram;
    ram_n <= ~ram;
    adr <= a;
    rd_n <= 1'b0;
    repeat (5) @(posedge clk);
    d = host_out.data;
    oe = host_out.data_oe;
    rd_n <= 1'b1;
    repeat (4) @(posedge clk);
    rtc_n <= 1'b1;
    ram_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* bench/tb.sv */
// Purpose: self-checking bench for the clock host bus interface
// Assumes: 200 MHz clk, host pins from host_model
// Notes: software side reached through small AXI4-Lite tasks
`timescale 1ns/10ps
`default_nettype none
module tb;
  import rtc_port_pkg::*;
  logic       clk       = 1'b0;
  logic       reset     = 1'b1;
  logic       inhibit_n = 1'b1;
  logic       rpin_n    = 1'b1;
  logic       sys_irq;
  logic       oe;
  logic       sq_q;
  logic [7:0] d;
  logic [31:0] rd;
  logic [1:0] rsp;
  host_in_s   host_in;
  host_out_s  host_out;
  rtc_event_s events    = '0;
  axi_req_s   axi_req   = '0;
  axi_rsp_s   axi_rsp;
  int         miscompares = 0;
  int         comparisons = 0;
  int         cycles      = 0;
  int         toggles     = 0;

  rtc_host_bus_interface i_rtc_host_bus_interface (.clk(clk), .reset(reset), .host_in(host_in),
    .host_out(host_out), .events(events), .axi_req(axi_req), .axi_rsp(axi_rsp), .sys_irq(sys_irq));
  host_model i_host_model (.clk(clk), .access_inhibit_n(inhibit_n), .reset_pin_n(rpin_n),
    .host_out(host_out), .host_in(host_in));

  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    sq_q <= host_out.square_wave_out;
    if (sq_q !== host_out.square_wave_out) toggles <= toggles + 1;
    if (cycles == 20000) begin
      miscompares++;
      end_sim();
    end
  end

  task automatic ck(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // valids held until their own ready; one spare edge so no signal is driven twice at once
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr <= a;
    axi_req.wvalid <= 1'b1;
    axi_req.wdata <= v;
    axi_req.wstrb <= 4'hF;
    axi_req.bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (axi_req.awvalid && axi_rsp.awready) axi_req.awvalid <= 1'b0;
      if (axi_req.wvalid && axi_rsp.wready) axi_req.wvalid <= 1'b0;
      if (axi_rsp.bvalid === 1'b1) begin
        rsp = axi_rsp.bresp;
        axi_req.bready <= 1'b0;
        break;
      end
    end
    @(posedge clk);
  endtask
  task automatic axr(input logic [7:0] a);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr <= a;
    axi_req.rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (axi_req.arvalid && axi_rsp.arready) axi_req.arvalid <= 1'b0;
      if (axi_rsp.rvalid === 1'b1) begin
        rd = axi_rsp.rdata;
        rsp = axi_rsp.rresp;
        axi_req.rready <= 1'b0;
        break;
      end
    end
    @(posedge clk);
  endtask
  task automatic cw(input logic [5:0] idx, input logic [7:0] v);
    i_host_model.hw(1'b0, 6'h00, {2'h0, idx});
    i_host_model.hw(1'b0, 6'h01, v);
  endtask
  task automatic cr(input logic [5:0] idx);
    i_host_model.hw(1'b0, 6'h00, {2'h0, idx});
    i_host_model.hr(1'b0, 6'h01, d, oe);
  endtask
  task automatic ev(input logic [3:0] m, input int gap);
    events <= rtc_event_s'(m);
    @(posedge clk);
    events <= '0;
    repeat (gap) @(posedge clk);
  endtask
  task automatic ticks(input int n);
    toggles = 0;
    repeat (n) ev(4'h1, 3);
    repeat (6) @(posedge clk);
  endtask

  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    cw(6'h10, 8'h5A);
    cw(6'h3F, 8'hC3);
    cr(6'h10);
    ck("clock byte 10", 8'h5A, d);
    ck("read drive", 1'b1, oe);
    i_host_model.hr(1'b0, 6'h00, d, oe);
    ck("pointer", 8'h10, d);
    cr(6'h3F);
    ck("clock byte 3F", 8'hC3, d);
    $display("test clock bank done");
    i_host_model.hw(1'b1, 6'h20, 8'h05);
    i_host_model.hw(1'b1, 6'h03, 8'hA5);
    i_host_model.hw(1'b1, 6'h3F, 8'hFF);
    i_host_model.hw(1'b1, 6'h1F, 8'h3C);
    i_host_model.hr(1'b1, 6'h25, d, oe);
    ck("page alias", 8'h7F, d);
    i_host_model.hr(1'b1, 6'h1F, d, oe);
    ck("ram 7F.1F", 8'h3C, d);
    i_host_model.hw(1'b1, 6'h21, 8'h05);
    i_host_model.hr(1'b1, 6'h03, d, oe);
    ck("ram 05.03", 8'hA5, d);
    $display("test extended ram done");
    axw(AXI_IRQ_STATUS, 32'h7);
    inhibit_n <= 1'b0;
    repeat (3) @(posedge clk);
    i_host_model.hw(1'b1, 6'h03, 8'h11);
    i_host_model.hr(1'b1, 6'h03, d, oe);
    ck("standby drive", 1'b0, oe);
    inhibit_n <= 1'b1;
    repeat (3) @(posedge clk);
    i_host_model.hr(1'b1, 6'h03, d, oe);
    ck("ram kept", 8'hA5, d);
    axr(AXI_IRQ_STATUS);
    ck("refused status", 32'h4, rd & 32'h5);
    axw(AXI_IRQ_MASK, 32'h1);
    axw(AXI_IRQ_STATUS, 32'h7);
    ck("sys_irq clear", 1'b0, sys_irq);
    i_host_model.hw(1'b1, 6'h03, 8'hA5);
    ck("sys_irq write", 1'b1, sys_irq);
    axw(AXI_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge clk);
    ck("sys_irq w1c", 1'b0, sys_irq);
    axr(8'h10);
    ck("unmapped resp", RESP_SLVERR, rsp);
    ck("unmapped data", 32'h0, rd);
    axw(8'h10, 32'h0);
    ck("unmapped write resp", RESP_SLVERR, rsp);
    axr(AXI_HOST_STAT);
    ck("page field", 7'h05, rd[16:10]);
    $display("test standby and software done");
    cw(REG_B, 8'h70);
    ev(4'h8, 4);
    ck("irq asserted", 1'b1, host_out.irq_oe);
    ck("irq level", 1'b0, host_out.irq_n);
    cr(REG_C);
    ck("summary bit", 1'b1, d[7]);
    ck("irq after read", 1'b0, host_out.irq_oe);
    cw(REG_B, 8'h20);
    ev(4'h6, 4);
    ck("irq masked", 1'b0, host_out.irq_oe);
    cw(REG_B, 8'h50);
    ck("irq enabled", 1'b1, host_out.irq_oe);
    cr(REG_C);
    $display("test interrupt done");
    cw(REG_A, 8'h83);
    cr(REG_A);
    ck("rate bits", 8'h03, d);
    cw(REG_B, 8'h08);
    ticks(8);
    ck("square toggles", 4, toggles);
    cw(REG_A, 8'h00);
    ticks(8);
    ck("square off", 0, toggles);
    cw(REG_A, 8'h03);
    $display("test square wave done");
    cw(REG_B, 8'h78);
    ev(4'h8, 4);
    rpin_n <= 1'b0;
    repeat (4) @(posedge clk);
    ck("irq released", 1'b0, host_out.irq_oe);
    i_host_model.hr(1'b0, 6'h01, d, oe);
    ck("clock refused", 1'b0, oe);
    i_host_model.hr(1'b1, 6'h03, d, oe);
    ck("ram open", 8'hA5, d);
    rpin_n <= 1'b1;
    repeat (4) @(posedge clk);
    cr(REG_B);
    ck("enables cleared", 8'h00, d & 8'h78);
    cr(REG_C);
    ck("flags cleared", 8'h00, d);
    ticks(8);
    ck("square disabled", 0, toggles);
    $display("test reset pin done");
    end_sim();
  end
endmodule
`default_nettype wire
